// ---- dv/lps_test_top_tb.sv ----
// Self-checking bench for the loopback and pad scan test block.
`timescale 1ns/1ps
`default_nettype none
module lps_test_top_tb import lps_pkg::*;;
    logic hclk, hresetn, hsel, hwrite, tx_frame_start, tx_frame_done, collision_in, irq, hreadyout;
    logic internal_reset_n, scan_pad_override, serial_prom_out, serial_prom_oe_n, carrier_sense_ignore;
    logic codec_internal_loop, line_tx_enable, sixteen_collision_flag, scan_select_n, addr_enable_scan_clock;
    logic hresp, aen_bus_qual, line_rx_enable, sqe_error;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [LPS_IN_SEL-1:0] scan_pad_in;
    logic [LPS_OUT_STEPS-1:0] scan_pad_out, scan_pad_oe_n;
    int miscompares = 0;
    int compares = 0;
    lps_test_top i_lps_test_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .irq, .scan_select_n, .addr_enable_scan_clock,
        .scan_pad_in, .tx_frame_start, .tx_frame_done, .collision_in, .aen_bus_qual, .internal_reset_n,
        .scan_pad_override, .scan_pad_out, .scan_pad_oe_n, .serial_prom_out, .serial_prom_oe_n,
        .carrier_sense_ignore, .codec_internal_loop, .line_tx_enable, .line_rx_enable, .sqe_error,
        .sixteen_collision_flag);
    lps_tester i_lps_tester (.scan_select_n, .addr_enable_scan_clock);
    // The 200 MHz bus clock.
    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Waits for hready under a bound; a hang ends the run.
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 99);
        if (n >= 99 && hreadyout !== 1'b1) begin
            miscompares++;
            conclude();
        end
    endtask
    // One single-word AHB-Lite transfer; read data lands in q.
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, w, 24'h0, a};
        wait_ready();
        {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
        wait_ready();
        q = hrdata;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h0);
        chk({hresp, q}, {1'b0, e});
    endtask
    // Every test mode decode and its loop and carrier outputs.
    task automatic t_modes();
        logic [3:0] cf [8] = '{4'h6, 4'h2, 4'h4, 4'h0, 4'hB, 4'h9, 4'h8, 4'hA};
        logic [7:0] m;
        for (int i = 0; i < 8; i++) begin
            m = 8'h01 << i;
            ahb(1'b1, LPS_OFF_TCTL, {21'h0, cf[i][0], cf[i][1], 8'h0, cf[i][3]});
            ahb(1'b1, LPS_OFF_ANEG, {16'h0, cf[i][2], 15'h0});
            ahb(1'b0, LPS_OFF_STAT, 32'h0);
            chk(q[7:0], m);
            chk(carrier_sense_ignore, (m & 8'h35) != 0);
            chk({codec_internal_loop, line_tx_enable, line_rx_enable}, (m & 8'h13) != 0 ? 3'h4 : 3'h3);
        end
    endtask
    // Sixteen collisions in the attachment collision mode, then clearing.
    task automatic t_coll();
        ahb(1'b1, LPS_OFF_TCTL, 32'h1);
        @(posedge hclk) tx_frame_start <= 1'b1;
        @(posedge hclk) tx_frame_start <= 1'b0;
        for (int i = 1; i <= 16; i++) begin
            @(posedge hclk) collision_in <= 1'b1;
            @(posedge hclk) collision_in <= 1'b0;
            @(posedge hclk);
            #1 chk(sixteen_collision_flag, i == 16);
        end
        ahb(1'b1, LPS_OFF_IRQM, 32'h1);
        chk(irq, 1'b1);
        rd(LPS_OFF_TXEV, 32'h8000);
        ahb(1'b1, LPS_OFF_TXEV, 32'h8000);
        ahb(1'b1, LPS_OFF_IRQS, 32'h1);
        chk({irq, sixteen_collision_flag}, 2'h0);
    endtask
    // External attachment loopback reports a quality error at frame end.
    task automatic t_sqe();
        ahb(1'b1, LPS_OFF_TCTL, 32'h401);
        @(posedge hclk) tx_frame_done <= 1'b1;
        @(posedge hclk) tx_frame_done <= 1'b0;
        #1 chk({sqe_error, irq}, 2'h2);
        repeat (2) @(posedge hclk);
        rd(LPS_OFF_IRQS, 32'h2);
    endtask
    // A full continuity pass plus the first step of the next one.
    task automatic t_scan();
        i_lps_tester.blocked();
        chk({internal_reset_n, aen_bus_qual}, 2'h3);
        rd(LPS_OFF_STAT, 32'h00021020);
        i_lps_tester.leave();
        i_lps_tester.enter();
        chk({internal_reset_n, scan_pad_override, line_tx_enable, scan_pad_oe_n}, {3'h2, {42{1'b1}}});
        i_lps_tester.fall(1);
        chk({scan_pad_oe_n, scan_pad_out}, {42'h0, ~42'h1});
        i_lps_tester.fall(41);
        chk(scan_pad_out, {~(42'h1 << 41)});
        i_lps_tester.fall(1);
        chk({scan_pad_oe_n, serial_prom_oe_n, serial_prom_out}, {{42{1'b1}}, 2'h1});
        i_lps_tester.fall(1);
        chk(serial_prom_out, 1'b0);
        i_lps_tester.fall(41);
        chk({scan_pad_oe_n, serial_prom_oe_n}, {43{1'b1}});
        i_lps_tester.fall(1);
        chk(scan_pad_out, {~42'h1});
        i_lps_tester.leave();
        chk({internal_reset_n, scan_pad_override, scan_pad_oe_n}, {2'h2, {42{1'b1}}});
        rd(LPS_OFF_TCTL, 32'h0);
        rd(LPS_OFF_IRQS, 32'hE);
    endtask
    // Reset, then the scenarios in turn.
    initial begin
        {hresetn, hsel, hwrite, tx_frame_start, tx_frame_done, collision_in} = 6'h0;
        {htrans, haddr, hwdata} = 66'h0;
        hsize = 3'h2;
        scan_pad_in = 53'h0A5A5A5A5A5A5;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (3) @(posedge hclk);
        t_modes();
        t_coll();
        t_sqe();
        t_scan();
        rd(8'h40, 32'h0);
        conclude();
    end
endmodule
`default_nettype wire

// ---- dv/lps_tester.sv ----
// Board tester model driving the scan select and scan clock pins.
`timescale 1ns/1ps
`default_nettype none
module lps_tester (
    output logic scan_select_n,
    output logic addr_enable_scan_clock
);
    // The scan clock starts low, but blocked raises it outside a scan; select idles high.
    initial begin
        scan_select_n = 1'b1;
        addr_enable_scan_clock = 1'b0;
    end
    task automatic enter();
        addr_enable_scan_clock = 1'b0;
        #48 scan_select_n = 1'b0;
        #48;
    endtask
    task automatic blocked();
        addr_enable_scan_clock = 1'b1;
        #48 scan_select_n = 1'b0;
        #48;
    endtask
    task automatic fall(input int n);
        repeat (n) begin
            addr_enable_scan_clock = 1'b1;
            #24 addr_enable_scan_clock = 1'b0;
            #24;
        end
    endtask
    task automatic leave();
        scan_select_n = 1'b1;
        #48;
    endtask
endmodule
`default_nettype wire

// ---- inc/lps_pkg.sv ----
// Constants, types and register map of the loopback and pad scan test block.
package lps_pkg;
    // ==================================================================
    // Register byte offsets on the AHB-Lite slave
    localparam logic [7:0] LPS_OFF_TCTL = 8'h00;
    localparam logic [7:0] LPS_OFF_ANEG = 8'h04;
    localparam logic [7:0] LPS_OFF_TXEV = 8'h08;
    localparam logic [7:0] LPS_OFF_STAT = 8'h0C;
    localparam logic [7:0] LPS_OFF_IRQS = 8'h10;
    localparam logic [7:0] LPS_OFF_IRQM = 8'h14;
    // ==================================================================
    // Field positions
    localparam int LPS_BIT_PORT_AUI = 0;
    localparam int LPS_BIT_CLOOP = 9;
    localparam int LPS_BIT_ALOOP = 10;
    localparam int LPS_BIT_FFD = 15;
    localparam int LPS_BIT_COLL16 = 15;
    localparam int LPS_STAT_MODE_LSB = 0;
    localparam int LPS_STAT_CNT_LSB = 8;
    localparam int LPS_STAT_SCAN_BIT = 16;
    localparam int LPS_STAT_BLOCK_BIT = 17;
    localparam int LPS_STAT_STEP_LSB = 24;
    // Interrupt status and mask bit positions.
    localparam int LPS_IRQ_W = 4;
    localparam int LPS_IRQ_COLL16 = 0;
    localparam int LPS_IRQ_SQE = 1;
    localparam int LPS_IRQ_SCAN_IN = 2;
    localparam int LPS_IRQ_SCAN_OUT = 3;
    // ==================================================================
    // Scan and collision counts
    localparam int LPS_OUT_PADS = 26;
    localparam int LPS_BIDIR_PADS = 16;
    localparam int LPS_OUT_STEPS = LPS_OUT_PADS + LPS_BIDIR_PADS;
    localparam int LPS_IN_PADS = 37;
    localparam int LPS_IN_SEL = LPS_IN_PADS + LPS_BIDIR_PADS;
    localparam logic [6:0] LPS_STEP_OUT_LAST = 7'h2A;
    localparam logic [6:0] LPS_STEP_IN_FIRST = 7'h2B;
    localparam logic [6:0] LPS_STEP_LAST = 7'h54;
    localparam logic [4:0] LPS_COLL_LIMIT = 5'h10;
    // ==================================================================
    // Types
    typedef enum logic [7:0] {
        LPS_M_NONE = 8'h00, LPS_M_TP_ILOOP = 8'h01, LPS_M_TP_ICOLL = 8'h02,
        LPS_M_TP_ELOOP = 8'h04, LPS_M_TP_ECOLL = 8'h08, LPS_M_AUI_ILOOP = 8'h10,
        LPS_M_AUI_ELOOP = 8'h20, LPS_M_AUI_COLL = 8'h40, LPS_M_AUI_RSVD = 8'h80
    } lps_mode_t;
    typedef enum logic [2:0] {
        LPS_S_NORMAL = 3'h1, LPS_S_SCAN = 3'h2, LPS_S_BLOCKED = 3'h4
    } lps_scan_t;
    typedef struct packed {
        logic port_aui;
        logic force_full_duplex;
        logic codec_loop;
        logic attachment_loop;
    } lps_cfg_t;
endpackage

// ---- rtl/lps_test_top.sv ----
// Loopback, collision test mode and pad continuity scan logic.
`timescale 1ns/1ps
`default_nettype none
module lps_test_top
    import lps_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic irq,
    input wire logic scan_select_n,
    input wire logic addr_enable_scan_clock,
    input wire logic [LPS_IN_SEL-1:0] scan_pad_in,
    input wire logic tx_frame_start,
    input wire logic tx_frame_done,
    input wire logic collision_in,
    output logic aen_bus_qual,
    output logic internal_reset_n,
    output logic scan_pad_override,
    output logic [LPS_OUT_STEPS-1:0] scan_pad_out,
    output logic [LPS_OUT_STEPS-1:0] scan_pad_oe_n,
    output logic serial_prom_out,
    output logic serial_prom_oe_n,
    output logic carrier_sense_ignore,
    output logic codec_internal_loop,
    output logic line_tx_enable,
    output logic line_rx_enable,
    output logic sqe_error,
    output logic sixteen_collision_flag
);
    // ==================================================================
    // Declarations
    lps_cfg_t cfg_ff;               // Software test configuration.
    lps_mode_t mode_ff;             // Decoded test mode.
    lps_scan_t scan_ff;             // Pad scan state.
    logic [1:0] sel_sync_ff;        // Scan select synchroniser.
    logic [1:0] aen_sync_ff;        // Address enable synchroniser.
    logic [LPS_IN_SEL-1:0] pin_s1_ff; // Input pad synchroniser, first stage.
    logic [LPS_IN_SEL-1:0] pin_s2_ff; // Input pad synchroniser, second stage.
    logic sel_prev_ff;              // Last synchronised select level.
    logic aen_prev_ff;              // Last synchronised address enable level.
    logic [6:0] step_ff;            // Scan step counter.
    logic [6:0] nxt_step;           // Next step count on a scan edge.
    logic [LPS_OUT_STEPS-1:0] pad_out_ff;
    logic [LPS_OUT_STEPS-1:0] pad_oe_n_ff;
    logic prom_out_ff;
    logic prom_oe_n_ff;
    logic [4:0] coll_cnt_ff;        // Collisions of the current frame.
    logic coll16_ff;                // Sixteen collision flag.
    logic sqe_ff;                   // Quality error pulse.
    logic [LPS_IRQ_W-1:0] irq_st_ff;
    logic [LPS_IRQ_W-1:0] irq_msk_ff;
    logic [LPS_IRQ_W-1:0] irq_set;
    logic wr_pend_ff;               // Write data phase pending.
    logic [7:0] wr_addr_ff;         // Write offset of the pending phase.
    logic [31:0] rdata_ff;
    logic sel_s;
    logic aen_s;
    logic aen_fall;
    logic scan_on;
    logic coll_mode;
    logic coll16_evt;
    logic addr_phase;
    logic wr_tctl;
    logic wr_aneg;
    logic wr_txev;
    logic wr_irqs;
    logic wr_irqm;

    // Map the two control pairs and the port select onto one test mode.
    function automatic lps_mode_t lps_decode_mode(input lps_cfg_t c);
        lps_mode_t m;
        m = LPS_M_NONE;
        if (c.port_aui) begin
            case ({c.attachment_loop, c.codec_loop})
                2'h3: m = LPS_M_AUI_ILOOP;
                2'h2: m = LPS_M_AUI_ELOOP;
                2'h1: m = LPS_M_AUI_RSVD;
                default: m = LPS_M_AUI_COLL;
            endcase
        end else begin
            case ({c.force_full_duplex, c.codec_loop})
                2'h3: m = LPS_M_TP_ILOOP;
                2'h1: m = LPS_M_TP_ICOLL;
                2'h2: m = LPS_M_TP_ELOOP;
                default: m = LPS_M_TP_ECOLL;
            endcase
        end
        return m;
    endfunction

    // ==================================================================
    // Pin synchronisers
    // Every pin from the tester passes two flip-flops before use.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sel_sync_ff <= 2'h3;
            aen_sync_ff <= 2'h0;
            pin_s1_ff <= '0;
            pin_s2_ff <= '0;
            sel_prev_ff <= 1'h1;
            aen_prev_ff <= 1'h0;
        end else begin
            sel_sync_ff <= {sel_sync_ff[0], scan_select_n};
            aen_sync_ff <= {aen_sync_ff[0], addr_enable_scan_clock};
            pin_s1_ff <= scan_pad_in;
            pin_s2_ff <= pin_s1_ff;
            sel_prev_ff <= sel_sync_ff[1];
            aen_prev_ff <= aen_sync_ff[1];
        end
    end

    assign sel_s = sel_sync_ff[1];
    assign aen_s = aen_sync_ff[1];
    assign scan_on = (scan_ff == LPS_S_SCAN);
    assign aen_fall = scan_on && aen_prev_ff && !aen_s;

    // ==================================================================
    // Pad scan state machine
    // Entry needs address enable low at the select fall, else it waits for select high.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            scan_ff <= LPS_S_NORMAL;
        end else begin
            case (scan_ff)
                LPS_S_NORMAL: begin
                    if (!sel_s && sel_prev_ff) begin
                        scan_ff <= aen_s ? LPS_S_BLOCKED : LPS_S_SCAN;
                    end
                end
                LPS_S_SCAN: begin
                    if (sel_s) begin
                        scan_ff <= LPS_S_NORMAL;
                    end
                end
                LPS_S_BLOCKED: begin
                    if (sel_s) begin
                        scan_ff <= LPS_S_NORMAL;
                    end
                end
                default: scan_ff <= LPS_S_NORMAL;
            endcase
        end
    end

    assign internal_reset_n = !scan_on;
    assign scan_pad_override = scan_on;
    // address enable back to the bus
    assign aen_bus_qual = scan_on ? 1'h0 : aen_s;

    // ==================================================================
    // Scan step counter and pad drive
    // Step 0 is released; 1 to 42 walk the zero; 43 to 84 read inputs.
    always_comb begin
        nxt_step = (step_ff == LPS_STEP_LAST) ? 7'h00 : step_ff + 7'h01;
    end

    // counter cleared on entry, advanced on edges
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            step_ff <= 7'h00;
        end else if (!scan_on) begin
            step_ff <= 7'h00;
        end else if (aen_fall) begin
            step_ff <= nxt_step;
        end
    end

    // Pads are driven from flip-flops that follow the step count.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pad_out_ff <= '1;
            pad_oe_n_ff <= '1;
        end else if (!scan_on) begin
            pad_out_ff <= '1;
            pad_oe_n_ff <= '1;
        end else if (aen_fall) begin
            if (nxt_step != 7'h00 && nxt_step <= LPS_STEP_OUT_LAST) begin
                pad_oe_n_ff <= '0;
                // index 0 is the link LED pad
                pad_out_ff <= ~(42'h1 << (nxt_step - 7'h01));
            end else begin
                // release in input phase and after
                pad_out_ff <= '1;
                pad_oe_n_ff <= '1;
            end
        end
    end

    // The selected input pad level goes to the serial prom output.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prom_out_ff <= 1'h1;
            prom_oe_n_ff <= 1'h1;
        end else if (!scan_on) begin
            prom_out_ff <= 1'h1;
            prom_oe_n_ff <= 1'h1;
        end else if (aen_fall) begin
            if (nxt_step >= LPS_STEP_IN_FIRST) begin
                prom_oe_n_ff <= 1'h0;
                // index 0 is the sleep pad
                prom_out_ff <= pin_s2_ff[6'(nxt_step - LPS_STEP_IN_FIRST)];
            end else begin
                prom_out_ff <= 1'h1;
                prom_oe_n_ff <= 1'h1;
            end
        end
    end

    assign scan_pad_out = pad_out_ff;
    assign scan_pad_oe_n = pad_oe_n_ff;
    assign serial_prom_out = prom_out_ff;
    assign serial_prom_oe_n = prom_oe_n_ff;

    // ==================================================================
    // Test mode decode and line control
    // The mode is registered; scan resets it with the rest of the core.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_ff <= LPS_M_TP_ECOLL;
        end else if (scan_on) begin
            mode_ff <= LPS_M_TP_ECOLL;
        end else begin
            mode_ff <= lps_decode_mode(cfg_ff);
        end
    end

    assign carrier_sense_ignore = mode_ff inside {LPS_M_TP_ILOOP, LPS_M_TP_ELOOP, LPS_M_AUI_ILOOP, LPS_M_AUI_ELOOP};
    assign codec_internal_loop = mode_ff inside {LPS_M_TP_ILOOP, LPS_M_TP_ICOLL, LPS_M_AUI_ILOOP};
    assign line_tx_enable = !codec_internal_loop && !scan_on;
    assign line_rx_enable = !codec_internal_loop && !scan_on;
    assign coll_mode = mode_ff inside {LPS_M_TP_ICOLL, LPS_M_TP_ECOLL, LPS_M_AUI_COLL};

    // ==================================================================
    // Collision counting and quality error
    // count collisions per frame
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            coll_cnt_ff <= 5'h00;
        end else if (scan_on || tx_frame_start) begin
            coll_cnt_ff <= 5'h00;
        end else if (coll_mode && collision_in && coll_cnt_ff != LPS_COLL_LIMIT) begin
            coll_cnt_ff <= coll_cnt_ff + 5'h01;
        end
    end

    assign coll16_evt = coll_mode && collision_in && !tx_frame_start && !scan_on
                        && (coll_cnt_ff == LPS_COLL_LIMIT - 5'h01);

    // sticky flag, set wins over clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            coll16_ff <= 1'h0;
        end else if (coll16_evt) begin
            coll16_ff <= 1'h1;
        end else if (scan_on || (wr_txev && hwdata[LPS_BIT_COLL16])) begin
            coll16_ff <= 1'h0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sqe_ff <= 1'h0;
        end else begin
            sqe_ff <= (mode_ff == LPS_M_AUI_ELOOP) && tx_frame_done && !scan_on;
        end
    end

    assign sixteen_collision_flag = coll16_ff;
    assign sqe_error = sqe_ff;

    // ==================================================================
    // AHB-Lite slave
    // Zero wait states; reads answer from a register in the data phase.
    assign addr_phase = hsel && hready && htrans[1];
    assign hreadyout = 1'h1;
    assign hresp = 1'h0;
    assign hrdata = rdata_ff;
    assign wr_tctl = wr_pend_ff && (wr_addr_ff == LPS_OFF_TCTL);
    assign wr_aneg = wr_pend_ff && (wr_addr_ff == LPS_OFF_ANEG);
    assign wr_txev = wr_pend_ff && (wr_addr_ff == LPS_OFF_TXEV);
    assign wr_irqs = wr_pend_ff && (wr_addr_ff == LPS_OFF_IRQS);
    assign wr_irqm = wr_pend_ff && (wr_addr_ff == LPS_OFF_IRQM);

    // Capture the address phase of a write.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_ff <= 1'h0;
            wr_addr_ff <= 8'h00;
        end else begin
            wr_pend_ff <= addr_phase && hwrite;
            wr_addr_ff <= {haddr[7:2], 2'h0};
        end
    end

    // Read data are selected at the address phase; unmapped reads give zero.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_ff <= 32'h0;
        end else if (addr_phase && !hwrite) begin
            rdata_ff <= 32'h0;
            case ({haddr[7:2], 2'h0})
                LPS_OFF_TCTL: begin
                    rdata_ff[LPS_BIT_PORT_AUI] <= cfg_ff.port_aui;
                    rdata_ff[LPS_BIT_CLOOP] <= cfg_ff.codec_loop;
                    rdata_ff[LPS_BIT_ALOOP] <= cfg_ff.attachment_loop;
                end
                LPS_OFF_ANEG: rdata_ff[LPS_BIT_FFD] <= cfg_ff.force_full_duplex;
                LPS_OFF_TXEV: rdata_ff[LPS_BIT_COLL16] <= coll16_ff;
                LPS_OFF_STAT: begin
                    rdata_ff[LPS_STAT_MODE_LSB +: 8] <= mode_ff;
                    rdata_ff[LPS_STAT_CNT_LSB +: 5] <= coll_cnt_ff;
                    rdata_ff[LPS_STAT_SCAN_BIT] <= scan_on;
                    rdata_ff[LPS_STAT_BLOCK_BIT] <= (scan_ff == LPS_S_BLOCKED);
                    rdata_ff[LPS_STAT_STEP_LSB +: 7] <= step_ff;
                end
                LPS_OFF_IRQS: rdata_ff[LPS_IRQ_W-1:0] <= irq_st_ff;
                LPS_OFF_IRQM: rdata_ff[LPS_IRQ_W-1:0] <= irq_msk_ff;
                default: rdata_ff <= 32'h0;
            endcase
        end
    end

    // Test configuration; cleared by the scan's internal reset.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_ff <= '0;
        end else if (scan_on) begin
            cfg_ff <= '0;
        end else begin
            if (wr_tctl) begin
                cfg_ff.port_aui <= hwdata[LPS_BIT_PORT_AUI];
                cfg_ff.codec_loop <= hwdata[LPS_BIT_CLOOP];
                cfg_ff.attachment_loop <= hwdata[LPS_BIT_ALOOP];
            end
            if (wr_aneg) begin
                cfg_ff.force_full_duplex <= hwdata[LPS_BIT_FFD];
            end
        end
    end

    // ==================================================================
    // Interrupts
    always_comb begin
        irq_set = '0;
        irq_set[LPS_IRQ_COLL16] = coll16_evt;
        irq_set[LPS_IRQ_SQE] = sqe_ff;
        irq_set[LPS_IRQ_SCAN_IN] = (scan_ff == LPS_S_NORMAL) && !sel_s && sel_prev_ff && !aen_s;
        irq_set[LPS_IRQ_SCAN_OUT] = scan_on && sel_s;
    end

    // Sticky status, write one to clear; a new event wins over the clear.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_st_ff <= '0;
            irq_msk_ff <= '0;
        end else begin
            irq_st_ff <= irq_set | (irq_st_ff & ~(wr_irqs ? hwdata[LPS_IRQ_W-1:0] : '0));
            if (wr_irqm) begin
                irq_msk_ff <= hwdata[LPS_IRQ_W-1:0];
            end
        end
    end

    assign irq = |(irq_st_ff & irq_msk_ff);

    // ==================================================================
    // Assertions
    default clocking lps_cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    carrier_ignore_a: assert property (mode_ff == LPS_M_AUI_ELOOP |-> carrier_sense_ignore && !codec_internal_loop)
        else $error("carrier sense not ignored in loopback");
    tp_decode_a: assert property (!scan_on && !cfg_ff.port_aui && !cfg_ff.force_full_duplex && cfg_ff.codec_loop ##1 !scan_on |-> mode_ff == LPS_M_TP_ICOLL)
        else $error("twisted-pair internal collision not decoded");
    coll_sixteen_a: assert property (coll16_evt |=> coll16_ff && coll_cnt_ff == LPS_COLL_LIMIT)
        else $error("sixteen collision flag not set");
    aui_decode_a: assert property (!scan_on && cfg_ff.port_aui && cfg_ff.attachment_loop && !cfg_ff.codec_loop ##1 !scan_on |-> mode_ff == LPS_M_AUI_ELOOP)
        else $error("attachment external loopback not decoded");
    sqe_report_a: assert property (mode_ff == LPS_M_AUI_ELOOP && tx_frame_done && !scan_on |=> sqe_error ##1 irq_st_ff[LPS_IRQ_SQE])
        else $error("quality error missing");
    int_path_a: assert property (codec_internal_loop |-> !line_tx_enable && !line_rx_enable)
        else $error("line driver on in internal mode");
    scan_enter_a: assert property (scan_ff == LPS_S_NORMAL && !sel_s && sel_prev_ff && !aen_s |=> scan_on && step_ff == 7'h00)
        else $error("scan mode not entered");
    hold_reset_a: assert property (scan_on |-> !internal_reset_n && !aen_bus_qual)
        else $error("internal reset released in scan");
    entry_hiz_a: assert property ($rose(scan_on) |-> &pad_oe_n_ff && prom_oe_n_ff)
        else $error("pads driven on scan entry");
    blocked_a: assert property (scan_ff == LPS_S_NORMAL && !sel_s && sel_prev_ff && aen_s |=> !scan_on [*2])
        else $error("scan entered with address enable high");
    walk_zero_a: assert property (scan_on && step_ff != 7'h00 && step_ff <= LPS_STEP_OUT_LAST
                                  |-> $countones(~pad_out_ff) == 1 && !pad_out_ff[6'(step_ff - 7'h01)])
        else $error("walking zero wrong");
    prom_copy_a: assert property (aen_fall && nxt_step >= LPS_STEP_IN_FIRST ##1 scan_on |-> !prom_oe_n_ff)
        else $error("prom output not driven in input phase");
    release_a: assert property (scan_on && step_ff == 7'h00 |-> &pad_oe_n_ff && prom_oe_n_ff)
        else $error("pads not released");
    wrap_a: assert property (aen_fall && step_ff == LPS_STEP_LAST |=> step_ff == 7'h00 || !scan_on)
        else $error("step counter did not wrap");
    exit_a: assert property (scan_on && sel_s |=> scan_ff == LPS_S_NORMAL ##1 internal_reset_n)
        else $error("scan mode not left");

    walk_cov: cover property (scan_on && step_ff == LPS_STEP_OUT_LAST);
    pass_cov: cover property (aen_fall && step_ff == LPS_STEP_LAST);
    coll_cov: cover property (coll16_evt);
    sqe_cov: cover property (sqe_ff && irq);
endmodule
`default_nettype wire
